// file: common/dma_out_pkg.sv
// Package: register map, reset values and carriers for the DMA OUT status block
package dma_out_pkg;
    localparam int ADDR_W = 16;
    localparam int PTR_W = 11;
    localparam int CNT_W = 16;
    localparam int CH_N = 2;
    localparam logic [15:0] CH1_READ_INDEX_LOW = 16'hffb6;
    localparam logic [15:0] CH1_READ_INDEX_HIGH = 16'hffb5;
    localparam logic [15:0] CH1_WRITE_INDEX_HIGH = 16'hffb7;
    localparam logic [15:0] CH1_WRITE_INDEX_LOW = 16'hffb8;
    localparam logic [15:0] CH0_READ_INDEX_HIGH = 16'hffb9;
    localparam logic [15:0] CH0_READ_INDEX_LOW = 16'hffba;
    localparam logic [15:0] CH0_WRITE_INDEX_HIGH = 16'hffbb;
    localparam logic [15:0] CH0_WRITE_INDEX_LOW = 16'hffbc;
    localparam logic [15:0] CH0_FILL_BYTES_LOW = 16'hffeb;
    localparam logic [15:0] CH0_FILL_BYTES_HIGH = 16'hffec;
    localparam logic [15:0] BULK_PACKET_TOTAL_HIGH = 16'hfff1;
    localparam logic [15:0] BULK_PACKET_TOTAL_LOW = 16'hfff2;
    localparam logic [15:0] CH1_FILL_BYTES_LOW = 16'hfff3;
    localparam logic [15:0] CH1_FILL_BYTES_HIGH = 16'hfff4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int HIGH_PTR_LSB = 8;
    localparam int HIGH_PTR_BITS = 3;
    localparam int BUF_DEPTH = 2;

    // Byte moved out of the buffer to the codec port
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } out_byte_t;

    // Microcontroller register access
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// file: rtl/skid_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module skid_buffer #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Filling side
    input wire logic in_valid_in,
    input wire dma_out_pkg::out_byte_t in_data_in,
    output logic in_ready_out,
    // Draining side
    output logic out_valid_out,
    output dma_out_pkg::out_byte_t out_data_out,
    input wire logic out_ready_in
);
    dma_out_pkg::out_byte_t mem_r [DEPTH];
    dma_out_pkg::out_byte_t mem_nxt [DEPTH];
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic wp_r;
    logic wp_nxt;
    logic rp_r;
    logic rp_nxt;
    logic push;
    logic pop;

    assign in_ready_out = (cnt_r != 2'(DEPTH));
    assign out_valid_out = (cnt_r != 2'h0);
    assign out_data_out = mem_r[rp_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data_in;
            wp_nxt = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        cnt_nxt = cnt_r + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            cnt_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
        end else begin
            mem_r <= mem_nxt;
            cnt_r <= cnt_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
endmodule

// file: rtl/dma_out_buffer_status.sv
// DMA OUT channel status: fill counts, bulk packet total, buffer indices
`timescale 1ns/10ps
// Summary of operation
// - Each isochronous OUT channel reports buffer bytes as 16-bit low and high bytes.
// - Byte count is captured at each start of frame and held that frame.
// - A 16-bit read/write bulk packet total for handshake mode, up to 64K.
// - Packet total reads back its current value at any time.
// - Write index exposed per channel: low byte, and bits 2:0 of high byte.
// - Write index bytes read without side effects and ignore writes.
// - Each channel's read index low byte is read-only and always readable.
// - Read and write index share one 11-bit space; difference is the fill.
// - Read index upper 3 bits sit read-only in bits 2:0 of a high byte.
// - Handshake mode moves one bulk packet, clears enable, raises an interrupt.
module dma_out_buffer_status #(
    parameter int PTR_W = dma_out_pkg::PTR_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Microcontroller register port
    input wire dma_out_pkg::reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    // USB buffer manager side
    input wire logic sof_in,
    input wire logic [1:0] usb_buffer_manager_write_in,
    // Per-channel data movers
    input wire logic [1:0] byte_valid_in,
    input wire logic [7:0] byte_data_in [2],
    input wire logic [1:0] byte_last_in,
    output logic [1:0] byte_ready_out,
    // Channel control
    input wire logic [1:0] channel_enable_set_in,
    input wire logic [1:0] handshake_mode_enable_in,
    output logic [1:0] channel_enable_out,
    output logic [1:0] packet_done_irq_out,
    // Codec port side
    output logic [1:0] codec_valid_out,
    output dma_out_pkg::out_byte_t codec_data_out [2],
    input wire logic [1:0] codec_ready_in
);
    // Per-channel indices and the fill captured at start of frame
    logic [PTR_W-1:0] wr_idx_r [2];
    logic [PTR_W-1:0] wr_idx_nxt [2];
    logic [PTR_W-1:0] rd_idx_r [2];
    logic [PTR_W-1:0] rd_idx_nxt [2];
    logic [15:0] fill_r [2];
    logic [15:0] fill_nxt [2];
    logic [1:0] en_r;
    logic [1:0] en_nxt;
    logic [1:0] irq_r;
    logic [1:0] irq_nxt;
    // Software-owned total and the registered read answer
    logic [15:0] total_r;
    logic [15:0] total_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [1:0] moved;
    logic [1:0] buf_ready;
    dma_out_pkg::out_byte_t buf_in [2];

    // Per-channel movement path and buffer
    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign buf_in[c] = '{data: byte_data_in[c], last: byte_last_in[c]};
        // Data moves only while the channel is enabled; a stall on the codec
        // side back-pressures the mover through the two-entry buffer
        assign byte_ready_out[c] = buf_ready[c] && en_r[c];
        assign moved[c] = byte_valid_in[c] && byte_ready_out[c];
        // Read index counts bytes into the buffer, not bytes the codec has taken
        skid_buffer #(.DEPTH(dma_out_pkg::BUF_DEPTH)) skid_buffer_i (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .in_valid_in(moved[c]),
            .in_data_in(buf_in[c]),
            .in_ready_out(buf_ready[c]),
            .out_valid_out(codec_valid_out[c]),
            .out_data_out(codec_data_out[c]),
            .out_ready_in(codec_ready_in[c])
        );
    end

    assign channel_enable_out = en_r;
    assign packet_done_irq_out = irq_r;
    assign reg_rdata_out = rdata_r;

    // Index, fill and enable state
    // The capture reads the indices as they stood before this edge, so a byte
    // that moves in the start-of-frame cycle is counted in the next frame
    always_comb begin
        en_nxt = en_r;
        irq_nxt = 2'h0;
        for (int c = 0; c < 2; c++) begin
            wr_idx_nxt[c] = wr_idx_r[c];
            rd_idx_nxt[c] = rd_idx_r[c];
            fill_nxt[c] = fill_r[c];
            if (usb_buffer_manager_write_in[c]) begin
                wr_idx_nxt[c] = wr_idx_r[c] + 1'b1;
            end
            if (moved[c]) begin
                rd_idx_nxt[c] = rd_idx_r[c] + 1'b1;
                if (handshake_mode_enable_in[c] && byte_last_in[c]) begin
                    en_nxt[c] = 1'b0;
                    irq_nxt[c] = 1'b1;
                end
            end
            if (sof_in) begin
                // Same 11-bit space, so the modulo difference is the fill
                fill_nxt[c] = 16'(PTR_W'(wr_idx_r[c] - rd_idx_r[c]));
            end
            // A set in the packet-end cycle wins, so a re-arm for the next
            // handshake packet is never lost
            if (channel_enable_set_in[c]) begin
                en_nxt[c] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int c = 0; c < 2; c++) begin
                wr_idx_r[c] <= '0;
                rd_idx_r[c] <= '0;
                fill_r[c] <= 16'h0000;
            end
            en_r <= 2'h0;
            irq_r <= 2'h0;
        end else begin
            wr_idx_r <= wr_idx_nxt;
            rd_idx_r <= rd_idx_nxt;
            fill_r <= fill_nxt;
            en_r <= en_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Register read and write; total is software-owned, software loads it
    // before setting enable
    always_comb begin
        total_nxt = total_r;
        // The answer stands for the one cycle after the read and is zero otherwise
        rdata_nxt = 8'h00;
        if (reg_req_in.wr) begin
            // Only the total is writable; index and fill bytes ignore writes
            if (reg_req_in.addr == dma_out_pkg::BULK_PACKET_TOTAL_LOW) begin
                total_nxt[7:0] = reg_req_in.wdata;
            end
            if (reg_req_in.addr == dma_out_pkg::BULK_PACKET_TOTAL_HIGH) begin
                total_nxt[15:8] = reg_req_in.wdata;
            end
        end
        if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                dma_out_pkg::CH0_FILL_BYTES_LOW: rdata_nxt = fill_r[0][7:0];
                dma_out_pkg::CH0_FILL_BYTES_HIGH: rdata_nxt = fill_r[0][15:8];
                dma_out_pkg::CH1_FILL_BYTES_LOW: rdata_nxt = fill_r[1][7:0];
                dma_out_pkg::CH1_FILL_BYTES_HIGH: rdata_nxt = fill_r[1][15:8];
                dma_out_pkg::BULK_PACKET_TOTAL_LOW: rdata_nxt = total_r[7:0];
                dma_out_pkg::BULK_PACKET_TOTAL_HIGH: rdata_nxt = total_r[15:8];
                dma_out_pkg::CH0_WRITE_INDEX_LOW: rdata_nxt = wr_idx_r[0][7:0];
                dma_out_pkg::CH0_WRITE_INDEX_HIGH: rdata_nxt = {5'h00, wr_idx_r[0][10:8]};
                dma_out_pkg::CH1_WRITE_INDEX_LOW: rdata_nxt = wr_idx_r[1][7:0];
                dma_out_pkg::CH1_WRITE_INDEX_HIGH: rdata_nxt = {5'h00, wr_idx_r[1][10:8]};
                dma_out_pkg::CH0_READ_INDEX_LOW: rdata_nxt = rd_idx_r[0][7:0];
                dma_out_pkg::CH0_READ_INDEX_HIGH: rdata_nxt = {5'h00, rd_idx_r[0][10:8]};
                dma_out_pkg::CH1_READ_INDEX_LOW: rdata_nxt = rd_idx_r[1][7:0];
                dma_out_pkg::CH1_READ_INDEX_HIGH: rdata_nxt = {5'h00, rd_idx_r[1][10:8]};
                // Unmapped offsets read as zero
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            total_r <= 16'h0000;
            rdata_r <= 8'h00;
        end else begin
            total_r <= total_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Checks
    a_fill_held_frame: assert property (@(posedge clk_in) disable iff (reset_in)
        !sof_in |=> $stable(fill_r[0])) else $error("fill count changed mid frame");
    a_fill_sof_capture: assert property (@(posedge clk_in) disable iff (reset_in)
        sof_in |=> fill_r[0] == 16'(PTR_W'($past(wr_idx_r[0]) - $past(rd_idx_r[0]))))
        else $error("fill count not captured at frame start");
    a_total_low_write: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.wr && reg_req_in.addr == dma_out_pkg::BULK_PACKET_TOTAL_LOW
        |=> total_r[7:0] == $past(reg_req_in.wdata)) else $error("total low not written");
    a_total_readback: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::BULK_PACKET_TOTAL_HIGH
        |=> rdata_r == $past(total_r[15:8])) else $error("total readback wrong");
    a_wr_index_high: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH0_WRITE_INDEX_HIGH
        |=> rdata_r[7:3] == 5'h00 && rdata_r[2:0] == $past(wr_idx_r[0][10:8]))
        else $error("write index high byte wrong");
    a_wr_index_static: assert property (@(posedge clk_in) disable iff (reset_in)
        !usb_buffer_manager_write_in[0] |=> $stable(wr_idx_r[0])) else $error("write index moved");
    a_rd_index_low: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH1_READ_INDEX_LOW
        |=> rdata_r == $past(rd_idx_r[1][7:0])) else $error("read index low byte wrong");
    a_rd_index_high: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH0_READ_INDEX_HIGH
        |=> rdata_r == {5'h00, $past(rd_idx_r[0][10:8])}) else $error("read index high byte wrong");
    a_handshake_stop: assert property (@(posedge clk_in) disable iff (reset_in)
        moved[0] && handshake_mode_enable_in[0] && byte_last_in[0] && !channel_enable_set_in[0]
        |=> !en_r[0] && irq_r[0] ##1 !irq_r[0]) else $error("handshake packet end not handled");
    a_rd_index_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
        moved[1] && rd_idx_r[1] == 11'h7ff |=> rd_idx_r[1] == 11'h000)
        else $error("read index did not wrap");
    a_index_space: assert property (@(posedge clk_in) disable iff (reset_in)
        sof_in |=> fill_r[1] == 16'(PTR_W'($past(wr_idx_r[1]) - $past(rd_idx_r[1]))))
        else $error("fill estimate not the index difference");

    // Hold on channel 1, and every fill byte readback
    a_fill_held_ch1: assert property (@(posedge clk_in) disable iff (reset_in)
        !sof_in |=> $stable(fill_r[1])) else $error("channel 1 fill count changed mid frame");
    a_fill_low_read: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH0_FILL_BYTES_LOW
        |=> rdata_r == $past(fill_r[0][7:0])) else $error("fill low byte readback wrong");
    a_fill_high_read: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH0_FILL_BYTES_HIGH
        |=> rdata_r == $past(fill_r[0][15:8])) else $error("fill high byte readback wrong");
    a_fill1_low_read: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH1_FILL_BYTES_LOW
        |=> rdata_r == $past(fill_r[1][7:0])) else $error("channel 1 fill low byte readback wrong");
    a_fill1_high_read: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH1_FILL_BYTES_HIGH
        |=> rdata_r == $past(fill_r[1][15:8])) else $error("channel 1 fill high byte readback wrong");

    // The total belongs to software: only its own writes move it
    a_total_high_write: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.wr && reg_req_in.addr == dma_out_pkg::BULK_PACKET_TOTAL_HIGH
        |=> total_r[15:8] == $past(reg_req_in.wdata)) else $error("total high not written");
    a_total_held: assert property (@(posedge clk_in) disable iff (reset_in)
        !reg_req_in.wr |=> $stable(total_r)) else $error("total changed without a write");
    a_total_low_read: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::BULK_PACKET_TOTAL_LOW
        |=> rdata_r == $past(total_r[7:0])) else $error("total low readback wrong");

    // Index bytes read back the live position, upper bits padded with zeros
    a_wr_index_low: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH0_WRITE_INDEX_LOW
        |=> rdata_r == $past(wr_idx_r[0][7:0])) else $error("write index low byte wrong");
    a_wr1_index_low: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH1_WRITE_INDEX_LOW
        |=> rdata_r == $past(wr_idx_r[1][7:0])) else $error("channel 1 write index low byte wrong");
    a_wr1_index_high: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH1_WRITE_INDEX_HIGH
        |=> rdata_r == {5'h00, $past(wr_idx_r[1][10:8])}) else $error("channel 1 write index high byte wrong");
    a_wr1_index_static: assert property (@(posedge clk_in) disable iff (reset_in)
        !usb_buffer_manager_write_in[1] |=> $stable(wr_idx_r[1])) else $error("channel 1 write index moved");
    a_rd0_index_low: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH0_READ_INDEX_LOW
        |=> rdata_r == $past(rd_idx_r[0][7:0])) else $error("channel 0 read index low byte wrong");
    a_rd_index_static: assert property (@(posedge clk_in) disable iff (reset_in)
        !moved[0] |=> $stable(rd_idx_r[0])) else $error("read index moved without a byte");
    a_rd1_index_static: assert property (@(posedge clk_in) disable iff (reset_in)
        !moved[1] |=> $stable(rd_idx_r[1])) else $error("channel 1 read index moved without a byte");
    a_rd1_index_high: assert property (@(posedge clk_in) disable iff (reset_in)
        reg_req_in.rd && reg_req_in.addr == dma_out_pkg::CH1_READ_INDEX_HIGH
        |=> rdata_r == {5'h00, $past(rd_idx_r[1][10:8])}) else $error("channel 1 read index high byte wrong");

    // Each index steps by one per byte and wraps at the top of the 11-bit space
    a_wr_index_step: assert property (@(posedge clk_in) disable iff (reset_in)
        usb_buffer_manager_write_in[0]
        |=> wr_idx_r[0] == PTR_W'($past(wr_idx_r[0]) + 1'b1)) else $error("write index did not step");
    a_wr1_index_step: assert property (@(posedge clk_in) disable iff (reset_in)
        usb_buffer_manager_write_in[1]
        |=> wr_idx_r[1] == PTR_W'($past(wr_idx_r[1]) + 1'b1)) else $error("channel 1 write index did not step");
    a_rd_index_step: assert property (@(posedge clk_in) disable iff (reset_in)
        moved[0]
        |=> rd_idx_r[0] == PTR_W'($past(rd_idx_r[0]) + 1'b1)) else $error("read index did not step");
    a_rd1_index_step: assert property (@(posedge clk_in) disable iff (reset_in)
        moved[1]
        |=> rd_idx_r[1] == PTR_W'($past(rd_idx_r[1]) + 1'b1)) else $error("channel 1 read index did not step");
    a_wr_index_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
        usb_buffer_manager_write_in[1] && wr_idx_r[1] == 11'h7ff
        |=> wr_idx_r[1] == 11'h000) else $error("write index did not wrap");

    // Handshake end of packet on channel 1, and where the interrupt comes from
    a_handshake_stop_ch1: assert property (@(posedge clk_in) disable iff (reset_in)
        moved[1] && handshake_mode_enable_in[1] && byte_last_in[1] && !channel_enable_set_in[1]
        |=> !en_r[1] && irq_r[1] ##1 !irq_r[1]) else $error("channel 1 packet end not handled");
    a_irq_cause: assert property (@(posedge clk_in) disable iff (reset_in)
        irq_r[0]
        |-> $past(moved[0] && handshake_mode_enable_in[0] && byte_last_in[0])) else $error("stray interrupt");
    a_irq_cause_ch1: assert property (@(posedge clk_in) disable iff (reset_in)
        irq_r[1]
        |-> $past(moved[1] && handshake_mode_enable_in[1] && byte_last_in[1])) else $error("stray channel 1 interrupt");
    a_irq_needs_enable: assert property (@(posedge clk_in) disable iff (reset_in)
        irq_r[0]
        |-> !en_r[0] || $past(channel_enable_set_in[0])) else $error("enable kept after packet end");
    a_stream_keeps_enable: assert property (@(posedge clk_in) disable iff (reset_in)
        moved[1] && !handshake_mode_enable_in[1]
        |=> en_r[1]) else $error("enable dropped outside handshake mode");
    a_enable_set_wins: assert property (@(posedge clk_in) disable iff (reset_in)
        channel_enable_set_in[0]
        |=> en_r[0]) else $error("enable set was lost");
    a_enable_held: assert property (@(posedge clk_in) disable iff (reset_in)
        en_r[0] && !moved[0]
        |=> en_r[0]) else $error("enable dropped without a packet end");
    a_enable_held_ch1: assert property (@(posedge clk_in) disable iff (reset_in)
        en_r[1] && !moved[1]
        |=> en_r[1]) else $error("channel 1 enable dropped without a packet end");
endmodule

// file: verif/codec_sink_model.sv
// Codec port sink model that stalls on command and every third cycle
`timescale 1ns/10ps
module codec_sink_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Stall control from the bench
    input wire logic hold_in,
    // Codec port
    input wire logic [1:0] valid_in,
    input wire dma_out_pkg::out_byte_t data_in [2],
    output logic [1:0] ready_out,
    // Observation
    output int count_out,
    output logic [8:0] last_out
);
    logic [1:0] phase_r;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_r <= 2'h0;
            count_out <= 0;
            last_out <= 9'h000;
        end else begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            for (int c = 0; c < 2; c++) begin
                if (valid_in[c] && ready_out[c]) begin
                    count_out <= count_out + 1;
                    last_out <= data_in[c];
                end
            end
        end
    end
    // Slow answers on purpose, so the buffer sees back-pressure every third cycle and while held
    assign ready_out = (hold_in || phase_r == 2'h2) ? 2'h0 : 2'h3;
endmodule

// file: verif/dma_out_buffer_status_tb.sv
// Self-checking bench for the DMA OUT status block
`timescale 1ns/10ps
module dma_out_buffer_status_tb;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    dma_out_pkg::reg_req_t req = '0;
    logic [7:0] rdata;
    logic sof = 1'b0;
    logic [1:0] usb_buffer_manager = 2'h0;
    logic [1:0] bvalid = 2'h0;
    logic [7:0] bdata [2] = '{8'h00, 8'h00};
    logic [1:0] blast = 2'h0;
    logic [1:0] ready;
    logic [1:0] en_set = 2'h0;
    logic [1:0] hsk = 2'h0;
    logic [1:0] en;
    logic [1:0] irq;
    logic [1:0] cvalid;
    dma_out_pkg::out_byte_t cdata [2];
    logic [1:0] cready;
    logic hold = 1'b0;
    int sunk;
    logic [8:0] sunk_last;
    int miscompares = 0;
    int n_compared = 0;
    // All readable offsets, every one of them zero out of reset
    logic [15:0] regs [14] = '{16'hffb5, 16'hffb6, 16'hffb7, 16'hffb8, 16'hffb9, 16'hffba, 16'hffbb,
        16'hffbc, 16'hffeb, 16'hffec, 16'hfff1, 16'hfff2, 16'hfff3, 16'hfff4};

    dma_out_buffer_status dma_out_buffer_status_i (.clk_in(clk_in), .reset_in(reset_in),
        .reg_req_in(req), .reg_rdata_out(rdata), .sof_in(sof), .usb_buffer_manager_write_in(usb_buffer_manager),
        .byte_valid_in(bvalid), .byte_data_in(bdata), .byte_last_in(blast), .byte_ready_out(ready),
        .channel_enable_set_in(en_set), .handshake_mode_enable_in(hsk), .channel_enable_out(en),
        .packet_done_irq_out(irq), .codec_valid_out(cvalid), .codec_data_out(cdata),
        .codec_ready_in(cready));
    codec_sink_model codec_sink_model_i (.clk_in(clk_in), .reset_in(reset_in), .hold_in(hold),
        .valid_in(cvalid), .data_in(cdata), .ready_out(cready), .count_out(sunk), .last_out(sunk_last));

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Read data is sampled in the cycle after the taking edge, its only valid cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_in) #1 req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in) #1 req.rd = 1'b0;
        chk($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_in) #1 req = '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in) #1 req.wr = 1'b0;
    endtask

    // Holds the byte until an edge samples ready high
    task automatic send(input logic [7:0] v, input logic last);
        int i;
        @(posedge clk_in) #1 bvalid[0] = 1'b1;
        bdata[0] = v;
        blast[0] = last;
        for (i = 0; i < 50 && ready[0] !== 1'b1; i++) @(posedge clk_in) #1;
        if (i == 50) begin
            chk("byte wait", 16'h0001, 16'h0000);
            wrap_up;
        end
        @(posedge clk_in) #1 bvalid[0] = 1'b0;
    endtask

    // Enables channel 1 and streams n bytes; an edge takes one when ready stood high before it
    task automatic stream(input int n);
        int k;
        int t;
        k = 0;
        @(posedge clk_in) #1 en_set = 2'h2;
        bvalid[1] = 1'b1;
        for (t = 0; t < 6000 && k < n; t++) begin
            if (ready[1] === 1'b1) k++;
            @(posedge clk_in) #1 en_set = 2'h0;
        end
        bvalid[1] = 1'b0;
        if (k < n) begin
            chk("stream wait", 16'h0001, 16'h0000);
            wrap_up;
        end
    endtask

    // One buffer manager deposit per cycle held high
    task automatic deposit(input int ch, input int n);
        @(posedge clk_in) #1 usb_buffer_manager[ch] = 1'b1;
        repeat (n) @(posedge clk_in);
        #1 usb_buffer_manager[ch] = 1'b0;
    endtask

    task automatic frame;
        @(posedge clk_in) #1 sof = 1'b1;
        @(posedge clk_in) #1 sof = 1'b0;
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        #1 reset_in = 1'b0;
        foreach (regs[k]) rd(regs[k], 8'h00);
        wr(16'hfff1, 8'h12);
        wr(16'hfff2, 8'h34);
        wr(16'hffbc, 8'h5a);
        rd(16'hfff1, 8'h12);
        rd(16'hfff2, 8'h34);
        rd(16'hffbc, 8'h00);
        rd(16'h0000, 8'h00);
        hsk = 2'h1;
        @(posedge clk_in) #1 en_set = 2'h1;
        @(posedge clk_in) #1 en_set = 2'h0;
        chk("enable", en, 16'h0001);
        hold = 1'b1;
        send(8'ha1, 1'b0);
        send(8'ha2, 1'b0);
        chk("ready full", ready[0], 16'h0000);
        rd(16'hfff2, 8'h34);
        hold = 1'b0;
        send(8'hc3, 1'b1);
        chk("enable end", en, 16'h0000);
        chk("irq", irq, 16'h0001);
        @(posedge clk_in) #1 chk("irq end", irq, 16'h0000);
        repeat (8) @(posedge clk_in);
        chk("sunk", sunk[15:0], 16'h0003);
        chk("sunk last", {7'h00, sunk_last}, 16'h0187);
        rd(16'hffba, 8'h03);
        rd(16'hffb9, 8'h00);
        deposit(0, 261);
        rd(16'hffbc, 8'h05);
        rd(16'hffbb, 8'h01);
        rd(16'hffeb, 8'h00);
        frame;
        rd(16'hffeb, 8'h02);
        rd(16'hffec, 8'h01);
        deposit(0, 4);
        rd(16'hffeb, 8'h02);
        deposit(1, 2050);
        rd(16'hffb8, 8'h02);
        rd(16'hffb7, 8'h00);
        frame;
        rd(16'hfff3, 8'h02);
        rd(16'hfff4, 8'h00);
        stream(2049);
        rd(16'hffb6, 8'h01);
        rd(16'hffb5, 8'h00);
        wrap_up;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        wrap_up;
    end
endmodule
